// *** design/frct_timer.v ***
// Sixteen-bit free-running timer with compare, capture, read buffer and shared-pin control
`include "frct_consts.vh"

// Functional notes
// R1: Software sets the pin direction bit to input before using capture.
// R2: Software clears direction bit and pin latch to drive the toggle output.
// R3: Port direction register resets to all ones, every pin input.
// R4: Direction bit 0 drives the pin, 1 releases it as input.
// R5: Counter is never cleared on match; matches repeat every full wrap.
// R6: Source select: 00 companion tick, 01 clock, 10 clock/4, 11 clock/32.
// R7: Count equal to compare raises match request; counting continues.
// R8: With toggling allowed each match inverts the pin; request still raised.
// R9: Enabling the timer output starts the toggle output low.
// R10: Edge select: 00 off, 01 rising, 10 falling, 11 both.
// R11: Selected capture edge loads the count within two clocks and holds it.
// R12: Software disables capture while reading the capture register.
// R13: Read buffer tracks count, freezes after the low-byte read.
// R14: Read buffer resumes tracking after the high-byte read.
// R15: Reset clears the counter to zero, then it free-runs.
// R16: Byte reads go low then high in pairs.
// R17: Counter keeps counting while clocked, so stop-mode exit count is undefined.
// R18: Software masks match request and clears toggle-allow before compare rewrite.
// R19: Compare rewrite equal to count raises the match request at the write.
// R20: Compare rewrite timing may double an interval or distort the toggle wave.
// R21: Byte rewrite of compare: high then low, then clear pending flag.
// R22: Match request lasts half a count period (one whole period with no divide here); toggle-allow set then inverts.
// R23: Toggle-allow 0 blocks inversion on match, 1 enables it.
// R24: Output enable 0 leaves port mode, 1 puts timer output on pin.
// R25: Compare register resets to all ones.
// R26: Wrap flag set by overflow, cleared only by software.
// R27: Counter increments once per count event and wraps to zero.
module frct_timer #(
    parameter CNT_W = 16,
    parameter ADDR_W = 18
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Avalon-MM slave
    input wire [ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // Companion timer tick
    input wire count_src_ext_i,
    // Shared pin
    input wire capture_in_pin_i,
    output wire toggle_out_pin_o,
    output wire toggle_out_pin_oe_o,
    // Match request
    output wire match_irq_o,
    output wire match_irq_pending_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [7:0] port_dir_q;
    reg [7:0] pin_latch_q;
    reg [1:0] src_sel_q;
    reg [1:0] edge_sel_q;
    reg toggle_allow_q;
    reg output_allow_q;
    reg wrap_flag_q;
    reg [CNT_W-1:0] free_run_counter_q;
    reg [CNT_W-1:0] match_value_reg_q;
    reg [CNT_W-1:0] capture_hold_reg_q;
    reg [CNT_W-1:0] read_buf_q;
    reg buf_frozen_q;
    reg match_level_q;
    reg match_irq_pending_q;
    reg match_irq_mask_q;
    reg toggle_q;
    reg cap_prev_q;
    reg cap_hit_q;
    reg ack_q;
    reg [31:0] rdata_q;

    wire tick;
    wire half;
    wire [15:0] idx = avs_address_i[17:2];
    wire req = avs_read_i | avs_write_i;
    wire acc = req & ack_q;
    wire wr = avs_write_i & acc;
    wire rd = avs_read_i & acc;
    wire be0 = avs_byteenable_i[0];
    wire [7:0] wd = avs_writedata_i[7:0];
    wire [CNT_W-1:0] count_next = free_run_counter_q + {{(CNT_W-1){1'b0}}, 1'b1};

    // ----------------------------------------
    // Count clock
    // ----------------------------------------
    frct_prescaler u_prescaler (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .src_sel_i(src_sel_q), // R6
        .ext_tick_i(count_src_ext_i),
        .tick_o(tick),
        .half_o(half)
    );

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One wait cycle on every access gives time to register the read data
    assign avs_waitrequest_o = req & ~ack_q;
    assign avs_readdata_o = rdata_q;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ----------------------------------------
    // Write and read decode
    // ----------------------------------------
    wire wr_mode = wr & be0 & (idx == `FRCT_IDX_MODE_CTRL);
    wire wr_irq = wr & be0 & (idx == `FRCT_IDX_IRQ_CTRL);
    wire wr_cmp = wr & (idx == `FRCT_IDX_MATCH_VAL);
    wire rd_lo = rd & (idx == `FRCT_IDX_COUNT_LO);
    wire rd_hi = rd & (idx == `FRCT_IDX_COUNT_HI);
    wire lo_req = avs_read_i & (idx == `FRCT_IDX_COUNT_LO);

    reg [CNT_W-1:0] cmp_d;
    always @* begin
        cmp_d = match_value_reg_q;
        if (wr_cmp && avs_byteenable_i[0]) begin
            cmp_d[7:0] = avs_writedata_i[7:0];
        end
        if (wr_cmp && avs_byteenable_i[1]) begin
            cmp_d[15:8] = avs_writedata_i[15:8];
        end
    end

    // ----------------------------------------
    // Match and wrap events
    // ----------------------------------------
    // A compare write that lands on the current count matches at once;
    // masking does not stop it; the mask bit gates neither the request nor the pending flag
    wire match_cnt = tick & (count_next == match_value_reg_q); // R7 R5
    wire match_wr = wr_cmp & (cmp_d == free_run_counter_q); // R19 R20
    wire match_ev = match_cnt | match_wr;
    wire wrap_ev = tick & (&free_run_counter_q); // R26
    wire toggle_rise = wr_mode & wd[`FRCT_MC_TOGGLE] & ~toggle_allow_q;
    wire out_rise = wr_mode & wd[`FRCT_MC_OUT_ALLOW] & ~output_allow_q;

    // ----------------------------------------
    // Counter and compare
    // ----------------------------------------
    // Counting never stops while the clock runs, except on the companion source with no ticks; this includes any oscillator wait
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            free_run_counter_q <= `FRCT_RST_COUNT; // R15
            match_value_reg_q <= `FRCT_RST_MATCH_VAL; // R25
        end else begin
            if (tick) begin
                free_run_counter_q <= count_next; // R27 R17
            end
            match_value_reg_q <= cmp_d;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            port_dir_q <= `FRCT_RST_PORT_DIR; // R3
            pin_latch_q <= 8'h00;
            src_sel_q <= 2'b00;
            edge_sel_q <= 2'b00;
            toggle_allow_q <= 1'b0;
            output_allow_q <= 1'b0;
            match_irq_mask_q <= `FRCT_RST_MASK;
        end else begin
            if (wr & be0 & (idx == `FRCT_IDX_PORT_DIR)) begin
                port_dir_q <= wd;
            end
            if (wr & be0 & (idx == `FRCT_IDX_PIN_LATCH)) begin
                pin_latch_q <= wd;
            end
            if (wr_mode) begin
                src_sel_q <= wd[`FRCT_MC_SRC_HI:`FRCT_MC_SRC_LO]; // R6
                edge_sel_q <= wd[`FRCT_MC_EDGE_HI:`FRCT_MC_EDGE_LO]; // R10
                toggle_allow_q <= wd[`FRCT_MC_TOGGLE]; // R23
                output_allow_q <= wd[`FRCT_MC_OUT_ALLOW]; // R24
            end
            if (wr_irq) begin
                match_irq_mask_q <= wd[`FRCT_IRQ_MASK];
            end
        end
    end

    // ----------------------------------------
    // Flags: hardware set wins over software clear
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            wrap_flag_q <= 1'b0;
            match_irq_pending_q <= 1'b0;
            match_level_q <= 1'b0;
        end else begin
            if (wrap_ev) begin
                wrap_flag_q <= 1'b1; // R26
            end else if (wr_mode && !wd[`FRCT_MC_WRAP]) begin
                wrap_flag_q <= 1'b0;
            end
            if (match_ev) begin
                match_irq_pending_q <= 1'b1; // R7
            end else if (wr_irq && !wd[`FRCT_IRQ_PENDING]) begin
                match_irq_pending_q <= 1'b0;
            end
            // Request stays high until the next half mark: half a count period when divided, one whole period with no divide
            if (match_ev) begin
                match_level_q <= 1'b1; // R22
            end else if (half) begin
                match_level_q <= 1'b0; // R22
            end
        end
    end

    assign match_irq_o = match_level_q;
    assign match_irq_pending_o = match_irq_pending_q;

    // ----------------------------------------
    // Toggle output
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            toggle_q <= 1'b0;
        end else if (out_rise) begin
            toggle_q <= 1'b0; // R9
        end else if (match_ev & toggle_allow_q) begin
            toggle_q <= ~toggle_q; // R8 R23
        end else if (toggle_rise & match_level_q) begin
            toggle_q <= ~toggle_q; // R22
        end
    end

    wire pin_dir_bit = port_dir_q[`FRCT_PIN_BIT];
    wire shared_pin_latch = pin_latch_q[`FRCT_PIN_BIT];
    assign toggle_out_pin_o = output_allow_q ? toggle_q : shared_pin_latch; // R24
    assign toggle_out_pin_oe_o = ~pin_dir_bit; // R4 R2

    // ----------------------------------------
    // Capture
    // ----------------------------------------
    // Pin is read even when driven; software keeps it an input for capture
    wire cap_rise = capture_in_pin_i & ~cap_prev_q;
    wire cap_fall = ~capture_in_pin_i & cap_prev_q;
    wire cap_edge = (edge_sel_q[0] & cap_rise) | (edge_sel_q[1] & cap_fall); // R10 R1

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cap_prev_q <= 1'b0;
            cap_hit_q <= 1'b0;
            capture_hold_reg_q <= {CNT_W{1'b0}};
        end else begin
            cap_prev_q <= capture_in_pin_i;
            cap_hit_q <= cap_edge;
            // Loaded one clock after the edge is seen; no read protection here
            if (cap_hit_q) begin
                capture_hold_reg_q <= free_run_counter_q; // R11 R12
            end
        end
    end

    // ----------------------------------------
    // Counter read buffer
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            buf_frozen_q <= 1'b0;
            read_buf_q <= `FRCT_RST_COUNT;
        end else begin
            if (rd_lo) begin
                buf_frozen_q <= 1'b1; // R13 R16
            end else if (rd_hi) begin
                buf_frozen_q <= 1'b0; // R14
            end
            // Held from the first cycle of the low-byte request, so the low byte handed out
            // and the high byte read later come from one and the same count
            if (!buf_frozen_q && !lo_req) begin
                read_buf_q <= free_run_counter_q; // R13
            end
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        case (idx)
            `FRCT_IDX_PORT_DIR: rdata_d[7:0] = port_dir_q;
            `FRCT_IDX_PIN_LATCH: rdata_d[7:0] = pin_latch_q;
            `FRCT_IDX_MODE_CTRL: begin
                rdata_d[7:0] = {toggle_out_pin_o, wrap_flag_q, edge_sel_q, toggle_allow_q, src_sel_q,
                    output_allow_q};
            end
            `FRCT_IDX_IRQ_CTRL: rdata_d[1:0] = {match_irq_mask_q, match_irq_pending_q};
            `FRCT_IDX_COUNT: rdata_d[15:0] = free_run_counter_q;
            `FRCT_IDX_MATCH_VAL: rdata_d[15:0] = match_value_reg_q;
            `FRCT_IDX_CAPTURE: rdata_d[15:0] = capture_hold_reg_q;
            `FRCT_IDX_COUNT_LO: rdata_d[7:0] = read_buf_q[7:0];
            `FRCT_IDX_COUNT_HI: rdata_d[7:0] = read_buf_q[15:8];
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i & ~ack_q) begin
            rdata_q <= rdata_d;
        end
    end

endmodule

// *** common/frct_consts.vh ***
// Register indexes, field positions, reset values and count-clock divides for the capture/compare timer
`ifndef FRCT_CONSTS_VH
`define FRCT_CONSTS_VH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define FRCT_IDX_PORT_DIR 16'hff23
`define FRCT_IDX_MODE_CTRL 16'hff48
`define FRCT_IDX_COUNT 16'hff40
`define FRCT_IDX_MATCH_VAL 16'hff41
`define FRCT_IDX_CAPTURE 16'hff42
`define FRCT_IDX_IRQ_CTRL 16'hff43
`define FRCT_IDX_PIN_LATCH 16'hff44
`define FRCT_IDX_COUNT_LO 16'hff45
`define FRCT_IDX_COUNT_HI 16'hff46

// ----------------------------------------
// Mode control fields
// ----------------------------------------
`define FRCT_MC_OUT_DATA 7
`define FRCT_MC_WRAP 6
`define FRCT_MC_EDGE_HI 5
`define FRCT_MC_EDGE_LO 4
`define FRCT_MC_TOGGLE 3
`define FRCT_MC_SRC_HI 2
`define FRCT_MC_SRC_LO 1
`define FRCT_MC_OUT_ALLOW 0

// ----------------------------------------
// Interrupt control fields, pin position in the port
// ----------------------------------------
`define FRCT_IRQ_PENDING 0
`define FRCT_IRQ_MASK 1
`define FRCT_PIN_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FRCT_RST_PORT_DIR 8'hff
`define FRCT_RST_MODE_CTRL 8'h00
`define FRCT_RST_MATCH_VAL 16'hffff
`define FRCT_RST_COUNT 16'h0000
`define FRCT_RST_MASK 1'b1

// ----------------------------------------
// Count source selects and divides
// ----------------------------------------
`define FRCT_SRC_EXT 2'b00
`define FRCT_SRC_DIV1 2'b01
`define FRCT_SRC_DIV4 2'b10
`define FRCT_SRC_DIV32 2'b11
`define FRCT_DIV4_LAST 5'h03
`define FRCT_DIV4_HALF 5'h01
`define FRCT_DIV32_LAST 5'h1f
`define FRCT_DIV32_HALF 5'h0f

`endif

// *** design/frct_prescaler.v ***
// Count-clock enable generator: external tick, main clock, main clock / 4 or / 32
`include "frct_consts.vh"

module frct_prescaler (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Control
    input wire [1:0] src_sel_i,
    input wire ext_tick_i,
    // Enables
    output reg tick_o,
    output reg half_o
);

    reg [4:0] div_q;
    reg ext_prev_q;
    reg [4:0] last_w;
    reg [4:0] half_w;

    always @* begin
        last_w = `FRCT_DIV32_LAST;
        half_w = `FRCT_DIV32_HALF;
        if (src_sel_i == `FRCT_SRC_DIV4) begin
            last_w = `FRCT_DIV4_LAST;
            half_w = `FRCT_DIV4_HALF;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            div_q <= 5'h00;
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_tick_i;
            if (div_q >= last_w) begin
                div_q <= 5'h00;
            end else begin
                div_q <= div_q + 5'h01;
            end
        end
    end

    // Half marks the middle of a count period; with no divide it equals the tick
    always @* begin
        case (src_sel_i)
            `FRCT_SRC_EXT: begin
                tick_o = ext_tick_i & ~ext_prev_q;
                half_o = ext_tick_i & ~ext_prev_q;
            end
            `FRCT_SRC_DIV1: begin
                tick_o = 1'b1;
                half_o = 1'b1;
            end
            default: begin
                tick_o = (div_q == last_w);
                half_o = (div_q == half_w);
            end
        endcase
    end

endmodule

// *** tb/frct_timer_props.sv ***
// Port-level assertions for the capture/compare timer
module frct_timer_props #(
    parameter CNT_W = 16,
    parameter ADDR_W = 18
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Bus
    input wire [ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    // Timer pins
    input wire count_src_ext_i,
    input wire capture_in_pin_i,
    input wire toggle_out_pin_o,
    input wire toggle_out_pin_oe_o,
    input wire match_irq_o,
    input wire match_irq_pending_o
);
    logic wr_done;
    assign wr_done = avs_write_i && !avs_waitrequest_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ----------------------------------------
    // Bus handshake steps
    // ----------------------------------------
    sequence s_req_start;
        $rose(avs_read_i) || $rose(avs_write_i);
    endsequence
    sequence s_taken;
        (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    endsequence
    a_read_answer: assert property (s_req_start |-> avs_waitrequest_o ##1 s_taken)
        else $error("bus answer not in the second cycle");
    a_wait_once: assert property (s_taken |=> !(avs_read_i || avs_write_i) || avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[ADDR_W-1:2] == 16'hff47
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    // ----------------------------------------
    // Timer outputs
    // ----------------------------------------
    a_reset_state: assert property ($rose(rst_b_i) |-> !toggle_out_pin_oe_o && !match_irq_o && !match_irq_pending_o)
        else $error("outputs not in reset state");
    a_irq_pend: assert property ($rose(match_irq_o) |-> match_irq_pending_o)
        else $error("match without pending flag");
    a_pend_cause: assert property ($rose(match_irq_pending_o) |-> match_irq_o)
        else $error("pending set without match");
    a_pend_sticky: assert property ($fell(match_irq_pending_o) |-> $past(wr_done))
        else $error("pending cleared without a write");
    a_irq_width: assert property ($rose(match_irq_o) |-> ##[1:17] !match_irq_o)
        else $error("match request too long");
    a_pin_cause: assert property ($changed(toggle_out_pin_o) |-> $rose(match_irq_o) || $past(wr_done))
        else $error("pin changed without match or write");
    a_oe_cause: assert property ($changed(toggle_out_pin_oe_o) |-> $past(wr_done))
        else $error("pin enable changed without a write");
endmodule

bind frct_timer frct_timer_props #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) frct_timer_props_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .count_src_ext_i(count_src_ext_i),
    .capture_in_pin_i(capture_in_pin_i), .toggle_out_pin_o(toggle_out_pin_o),
    .toggle_out_pin_oe_o(toggle_out_pin_oe_o), .match_irq_o(match_irq_o), .match_irq_pending_o(match_irq_pending_o));

// *** tb/tb_frct_timer.sv ***
// Self-checking testbench for the capture/compare timer
`include "frct_consts.vh"

module tb_frct_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0;
    logic rst_b_i = 0;
    logic [17:0] avs_address_i = '0;
    logic avs_read_i = 0;
    logic avs_write_i = 0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = '0;
    logic count_src_ext_i = 0;
    logic capture_in_pin_i = 0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, toggle_out_pin_o, toggle_out_pin_oe_o, match_irq_o, match_irq_pending_o;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] rd, a, b, v, cap;
    int s, k, t1, t2;

    frct_timer frct_timer_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .count_src_ext_i(count_src_ext_i),
        .capture_in_pin_i(capture_in_pin_i), .toggle_out_pin_o(toggle_out_pin_o),
        .toggle_out_pin_oe_o(toggle_out_pin_oe_o), .match_irq_o(match_irq_o),
        .match_irq_pending_o(match_irq_pending_o));

    initial forever #2 clk_i = ~clk_i;

    // Whole run is about 70k cycles, dominated by one full counter wrap
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_le(input logic [31:0] got, input logic [31:0] lim);
        checks++;
        if ((got <= lim) !== 1'b1) begin
            fail_count++;
            $display("BAD at %0t got %h limit %h", $time, got, lim);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Values read right at the rising edge are those the slave shows at that edge
    task automatic bus(input logic we, input logic [15:0] idx, input logic [31:0] wd, input logic [3:0] be);
        logic w;
        avs_read_i <= !we;
        avs_write_i <= we;
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        do begin
            @(posedge clk_i);
            w = avs_waitrequest_o;
            rd = avs_readdata_o;
        end while (w !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_irq(input int lim, output int at);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (match_irq_o !== 1'b1 && n < lim);
        at = cyc;
        chk_val(match_irq_o, 1'b1);
        @(posedge clk_i);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        a = $urandom(32'hbc77);
        wait_cyc(10);
        rst_b_i <= 1'b1;
        bus(0, `FRCT_IDX_COUNT, 0, 4'hf); chk_le(rd, 20);
        bus(0, `FRCT_IDX_PORT_DIR, 0, 4'hf); chk_val(rd, `FRCT_RST_PORT_DIR);
        bus(0, `FRCT_IDX_MATCH_VAL, 0, 4'hf); chk_val(rd, `FRCT_RST_MATCH_VAL);
        bus(0, `FRCT_IDX_MODE_CTRL, 0, 4'hf); chk_val(rd, `FRCT_RST_MODE_CTRL);
        bus(1, 16'hff47, 32'h5a, 4'hf);
        bus(0, 16'hff47, 0, 4'hf); chk_val(rd, 0);
        $display("test reset done");
        repeat (4) begin
            v = {24'h0, 3'b111, 5'($urandom)};
            bus(1, `FRCT_IDX_PORT_DIR, v, 4'h1);
            bus(0, `FRCT_IDX_PORT_DIR, 0, 4'hf); chk_val(rd, v);
            chk_val(toggle_out_pin_oe_o, !v[3]);
        end
        $display("test direction done");
        for (s = 0; s < 4; s++) begin
            bus(1, `FRCT_IDX_MODE_CTRL, s << 1, 4'h1);
            bus(0, `FRCT_IDX_COUNT, 0, 4'hf);
            a = rd;
            if (s == 0) repeat (4) begin
                count_src_ext_i <= 1'b1;
                wait_cyc(2);
                count_src_ext_i <= 1'b0;
                wait_cyc(2);
            end
            else wait_cyc(s == 1 ? 0 : (s == 2 ? 29 : 61));
            bus(0, `FRCT_IDX_COUNT, 0, 4'hf);
            chk_val((rd - a) & 32'hffff, s == 1 ? 3 : (s == 2 ? 8 : (s == 3 ? 2 : 4)));
        end
        $display("test count source done");
        bus(1, `FRCT_IDX_MODE_CTRL, 32'h02, 4'h1);
        for (k = 0; k < 2; k++) begin
            bus(0, `FRCT_IDX_COUNT, 0, 4'hf);
            a = rd;
            bus(0, `FRCT_IDX_COUNT_LO, 0, 4'hf);
            v = rd & 32'hff;
            wait_cyc(200 + $urandom % 100);
            bus(0, `FRCT_IDX_COUNT_HI, 0, 4'hf);
            v = v | ((rd & 32'hff) << 8);
            chk_le((v - a) & 32'hffff, 4);
        end
        $display("test read buffer done");
        bus(1, `FRCT_IDX_PORT_DIR, 32'hff, 4'h1);
        cap = 0;
        for (s = 0; s < 4; s++) begin
            bus(1, `FRCT_IDX_MODE_CTRL, (s << 4) | 32'h04, 4'h1);
            for (k = 1; k >= 0; k--) begin
                bus(0, `FRCT_IDX_COUNT, 0, 4'hf);
                a = rd;
                wait_cyc($urandom % 8);
                capture_in_pin_i <= k[0];
                wait_cyc(3);
                bus(0, `FRCT_IDX_COUNT, 0, 4'hf);
                b = rd;
                bus(0, `FRCT_IDX_CAPTURE, 0, 4'hf);
                if (s == 3 || (s == 1 && k == 1) || (s == 2 && k == 0)) chk_le((rd - a) & 32'hffff, b - a);
                else chk_val(rd, cap);
                cap = rd;
            end
        end
        $display("test capture done");
        bus(1, `FRCT_IDX_PORT_DIR, 32'hf7, 4'h1);
        bus(1, `FRCT_IDX_PIN_LATCH, 32'h08, 4'h1);
        chk_val(toggle_out_pin_o, 1'b1);
        bus(1, `FRCT_IDX_MODE_CTRL, 32'h03, 4'h1);
        chk_val(toggle_out_pin_o, 1'b0);
        bus(0, `FRCT_IDX_COUNT, 0, 4'hf);
        v = (rd + 200) & 32'hffff;
        bus(1, `FRCT_IDX_MATCH_VAL, v, 4'h3);
        bus(1, `FRCT_IDX_MODE_CTRL, 32'h0b, 4'h1);
        wait_irq(400, t1);
        chk_val(toggle_out_pin_o, 1'b1);
        chk_val(match_irq_pending_o, 1'b1);
        bus(0, `FRCT_IDX_COUNT, 0, 4'hf); chk_le((rd - v - 1) & 32'hffff, 20);
        bus(1, `FRCT_IDX_IRQ_CTRL, 32'h02, 4'h1);
        bus(0, `FRCT_IDX_IRQ_CTRL, 0, 4'hf); chk_val(rd, 32'h02);
        bus(1, `FRCT_IDX_MODE_CTRL, 32'h03, 4'h1);
        wait_irq(70000, t2);
        chk_val(t2 - t1, 65536);
        chk_val(toggle_out_pin_o, 1'b1);
        bus(0, `FRCT_IDX_MODE_CTRL, 0, 4'hf); chk_val(rd, 32'hc3);
        bus(1, `FRCT_IDX_MODE_CTRL, 32'h03, 4'h1);
        bus(0, `FRCT_IDX_MODE_CTRL, 0, 4'hf); chk_val(rd, 32'h83);
        // Companion source with no ticks holds the count still, so a compare write can land on it
        bus(1, `FRCT_IDX_MODE_CTRL, 32'h01, 4'h1);
        bus(1, `FRCT_IDX_IRQ_CTRL, 32'h02, 4'h1);
        bus(0, `FRCT_IDX_COUNT, 0, 4'hf);
        bus(1, `FRCT_IDX_MATCH_VAL, rd, 4'h3); chk_val(match_irq_pending_o, 1'b1);
        bus(1, `FRCT_IDX_MODE_CTRL, 32'h09, 4'h1); chk_val(toggle_out_pin_o, 1'b0);
        count_src_ext_i <= 1'b1;
        wait_cyc(2); chk_val(match_irq_o, 1'b0);
        count_src_ext_i <= 1'b0;
        $display("test match done");
        complete_run();
    end
endmodule
